// file: core/rmsq_sequencer.sv
// Run mode sequencer entered after a self-polling wake-up
`timescale 1ns/100ps
module rmsq_sequencer (
  input wire logic clk,
  input wire logic srst,
  input wire rmsq_pkg::rmsq_wb_req_t wb_req,
  output rmsq_pkg::rmsq_wb_rsp_t wb_rsp,
  input wire rmsq_pkg::rmsq_rx_ev_t rx_ev,
  output rmsq_pkg::rmsq_ctl_t ctl
);
  typedef struct packed {
    rmsq_pkg::rmsq_state_t state;
    logic [31:0] ctrl;
    logic [rmsq_pkg::TMR_W-1:0] sync_rel;
    logic [rmsq_pkg::TMR_W-1:0] fid_rel;
    logic [rmsq_pkg::TMR_W-1:0] eom_rel;
    logic [7:0] cap_chan;
    logic cap_cfg;
    logic cap_valid;
    logic ack;
    logic [31:0] rdat;
    logic pwu_armed;
    logic pwu_active;
    logic load_tmr;
    rmsq_pkg::rmsq_ctl_t out;
  } rmsq_seq_st_t;

  rmsq_seq_st_t q;
  rmsq_seq_st_t d;

  logic sync_exp;
  logic fid_exp;
  logic eom_exp;
  logic [rmsq_pkg::TMR_W-1:0] sync_cnt;
  logic [rmsq_pkg::TMR_W-1:0] fid_cnt;
  logic [rmsq_pkg::TMR_W-1:0] eom_cnt;
  logic ext_to;
  logic ext_eom;
  logic req;
  logic wr;
  logic cmd_wr;
  logic in_run;
  logic taken;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [rmsq_pkg::TMR_W-1:0] merge16(input logic [rmsq_pkg::TMR_W-1:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] w;
    w = merge({16'h0000, old}, nw, sel);
    return w[rmsq_pkg::TMR_W-1:0];
  endfunction

  // Unmapped offsets read zero
  function automatic logic [31:0] read_word(input rmsq_seq_st_t s, input logic [7:0] adr);
    logic [31:0] w;
    case (adr)
      rmsq_pkg::ADR_CTRL: w = {24'h00_0000, s.ctrl[7:0]};
      rmsq_pkg::ADR_SYNC_TO: w = {16'h0000, s.sync_rel};
      rmsq_pkg::ADR_FID_TO: w = {16'h0000, s.fid_rel};
      rmsq_pkg::ADR_EOM_TO: w = {16'h0000, s.eom_rel};
      rmsq_pkg::ADR_CAPTURE: w = {22'h00_0000, s.cap_valid, s.cap_cfg, s.cap_chan};
      rmsq_pkg::ADR_STATUS: w = {28'h000_0000, s.pwu_armed, s.pwu_active, s.state};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // One place fixes how a restart drives the polling timer and the off period
  function automatic rmsq_pkg::rmsq_ctl_t resume_ctl(input logic to_a, input logic ext, input logic last,
    input logic constant_on_off_polling);
    rmsq_pkg::rmsq_ctl_t c;
    c = '0;
    c.resume_cfga = to_a;
    c.off_go = !to_a && ext && last;
    c.resume_next = !to_a && !c.off_go;
    c.timer_init = to_a || constant_on_off_polling;
    return c;
  endfunction

  assign req = wb_req.cyc && wb_req.stb;
  // Taken only while ack is low, so a held request is answered every other cycle
  assign taken = req && !q.ack;
  // Write lands on the edge at which the master sees ack
  assign wr = req && wb_req.we && q.ack;
  assign cmd_wr = wr && (wb_req.adr == rmsq_pkg::ADR_CMD) && wb_req.sel[0];
  assign in_run = (q.state != rmsq_pkg::ST_POLL);

  rmsq_cmd_decode u_cmd (
    .clk(clk),
    .srst(srst),
    .wr(cmd_wr),
    .wdat(wb_req.dat[1:0]),
    .ext_sel(q.ctrl[rmsq_pkg::CTRL_EXT_LSB +: 2]),
    .ext_to(ext_to),
    .ext_eom(ext_eom)
  );

  // All three reload together; a zero reload parks that timer
  rmsq_timer u_sync_tmr (
    .clk(clk),
    .srst(srst),
    .load(q.load_tmr),
    .run(q.state == rmsq_pkg::ST_RUN && !rx_ev.sym_sync),
    .reload(q.sync_rel),
    .expire(sync_exp),
    .count(sync_cnt)
  );

  rmsq_timer u_fid_tmr (
    .clk(clk),
    .srst(srst),
    .load(q.load_tmr),
    .run(q.state == rmsq_pkg::ST_RUN),
    .reload(q.fid_rel),
    .expire(fid_exp),
    .count(fid_cnt)
  );

  rmsq_timer u_eom_tmr (
    .clk(clk),
    .srst(srst),
    .load(q.load_tmr),
    .run(q.state == rmsq_pkg::ST_PAYLOAD),
    .reload(q.eom_rel),
    .expire(eom_exp),
    .count(eom_cnt)
  );

  always_comb begin
    logic to_cfga;
    logic clr_frame;
    logic pwu_en;
    logic constant_on_off_polling;
    logic [1:0] eom_act;
    logic timeout;
    logic msg_end;
    logic do_resume;
    logic resume_a;
    logic cycle_start;
    d = q;
    to_cfga = q.ctrl[rmsq_pkg::CTRL_TO_CFGA];
    eom_act = q.ctrl[rmsq_pkg::CTRL_EOM_LSB +: 2];
    clr_frame = q.ctrl[rmsq_pkg::CTRL_CLR_FRAME];
    pwu_en = q.ctrl[rmsq_pkg::CTRL_PWU];
    constant_on_off_polling = q.ctrl[rmsq_pkg::CTRL_COO];
    do_resume = 1'b0;
    resume_a = 1'b0;
    cycle_start = 1'b0;
    d.load_tmr = 1'b0;
    d.out = '0;

    d.ack = taken;
    if (taken) begin
      d.rdat = read_word(q, wb_req.adr);
    end
    if (wr) begin
      case (wb_req.adr)
        rmsq_pkg::ADR_CTRL: d.ctrl = merge(q.ctrl, wb_req.dat, wb_req.sel) & 32'h0000_00ff;
        rmsq_pkg::ADR_SYNC_TO: d.sync_rel = merge16(q.sync_rel, wb_req.dat, wb_req.sel);
        rmsq_pkg::ADR_FID_TO: d.fid_rel = merge16(q.fid_rel, wb_req.dat, wb_req.sel);
        rmsq_pkg::ADR_EOM_TO: d.eom_rel = merge16(q.eom_rel, wb_req.dat, wb_req.sel);
        default: d.ctrl = q.ctrl;
      endcase
    end

    timeout = in_run && (sync_exp || fid_exp || eom_exp || ext_to);
    msg_end = (q.state == rmsq_pkg::ST_PAYLOAD && rx_ev.msg_end) || (in_run && ext_eom);

    case (q.state)
      rmsq_pkg::ST_POLL: begin
        if (rx_ev.wakeup) begin
          d.state = rmsq_pkg::ST_RUN;
          cycle_start = 1'b1;
        end
      end
      rmsq_pkg::ST_RUN: begin
        if (rx_ev.frame_start) begin
          d.state = rmsq_pkg::ST_PAYLOAD;
          d.pwu_active = 1'b0;
          if (clr_frame && !rx_ev.fifo_locked) begin
            d.out.fifo_clr = 1'b1;
          end
        end else if (q.pwu_active) begin
          if (rx_ev.wakeup) begin
            d.out.pwu_wakeup = 1'b1;
            d.pwu_active = 1'b0;
            d.pwu_armed = 1'b0;
            cycle_start = 1'b1;
          end else if (!rx_ev.sym_sync) begin
            // Stays disarmed until an end of message with the reload or spare action re-arms it
            d.pwu_active = 1'b0;
            d.pwu_armed = 1'b0;
          end
        end else if (q.pwu_armed && rx_ev.sym_sync) begin
          d.pwu_active = 1'b1;
        end
      end
      rmsq_pkg::ST_PAYLOAD: begin
        d.state = q.state;
      end
      default: begin
        d.state = rmsq_pkg::ST_POLL;
      end
    endcase

    // Timeout outranks end of message in the same cycle
    if (timeout) begin
      do_resume = 1'b1;
      resume_a = to_cfga;
    end else if (msg_end) begin
      if (rx_ev.msg_end && !ext_eom) begin
        d.cap_chan = rx_ev.channel;
        d.cap_cfg = rx_ev.cfg_b;
        d.cap_valid = 1'b1;
      end
      if (eom_act == rmsq_pkg::EOM_RELOAD || eom_act == rmsq_pkg::EOM_SPARE) begin
        d.state = rmsq_pkg::ST_RUN;
        d.load_tmr = 1'b1;
        d.pwu_armed = pwu_en;
        d.pwu_active = 1'b0;
        if (ext_eom) begin
          cycle_start = 1'b1;
        end
      end else begin
        do_resume = 1'b1;
        resume_a = (eom_act == rmsq_pkg::EOM_CFGA);
      end
      if (ext_eom) begin
        d.load_tmr = 1'b1;
      end
    end

    if (cycle_start) begin
      d.load_tmr = 1'b1;
      d.out.fifo_clr = !clr_frame;
    end

    if (do_resume) begin
      d.state = rmsq_pkg::ST_POLL;
      d.pwu_armed = 1'b0;
      d.pwu_active = 1'b0;
      d.out = d.out | resume_ctl(resume_a, ext_to || ext_eom, rx_ev.last_cfg, constant_on_off_polling);
    end

    // Wake-ups in run mode outside the parallel window never reach here
    d.out.run_mode = (d.state != rmsq_pkg::ST_POLL);
    d.out.pwu_active = d.pwu_active;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.state <= rmsq_pkg::ST_POLL;
      q.ctrl <= rmsq_pkg::CTRL_RST;
      q.sync_rel <= rmsq_pkg::SYNC_TO_RST;
      q.fid_rel <= rmsq_pkg::FID_TO_RST;
      q.eom_rel <= rmsq_pkg::EOM_TO_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_rsp.ack = q.ack;
  assign wb_rsp.dat = q.rdat;
  assign ctl = q.out;
endmodule

// file: shared/rmsq_pkg.sv
// Constants, types and carriers of the run mode sequencer
package rmsq_pkg;
  localparam int TMR_W = 16;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SYNC_TO = 8'h04;
  localparam logic [7:0] ADR_FID_TO = 8'h08;
  localparam logic [7:0] ADR_EOM_TO = 8'h0c;
  localparam logic [7:0] ADR_CMD = 8'h10;
  localparam logic [7:0] ADR_CAPTURE = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  localparam int CTRL_TO_CFGA = 0;
  localparam int CTRL_EOM_LSB = 1;
  localparam int CTRL_CLR_FRAME = 3;
  localparam int CTRL_PWU = 4;
  localparam int CTRL_COO = 5;
  localparam int CTRL_EXT_LSB = 6;
  localparam int CMD_EXT_TO = 0;
  localparam int CMD_EXT_EOM = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [TMR_W-1:0] SYNC_TO_RST = 16'h0400;
  localparam logic [TMR_W-1:0] FID_TO_RST = 16'h1000;
  localparam logic [TMR_W-1:0] EOM_TO_RST = 16'h4000;
  localparam logic [1:0] EXT_OFF = 2'h0;

  typedef enum logic [1:0] {EOM_NEXT, EOM_CFGA, EOM_RELOAD, EOM_SPARE} rmsq_eom_act_t;
  typedef enum logic [1:0] {ST_POLL, ST_RUN, ST_PAYLOAD} rmsq_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rmsq_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rmsq_wb_rsp_t;

  typedef struct packed {
    logic wakeup;
    logic sym_sync;
    logic frame_start;
    logic msg_end;
    logic fifo_locked;
    logic last_cfg;
    logic cfg_b;
    logic [7:0] channel;
  } rmsq_rx_ev_t;

  typedef struct packed {
    logic resume_next;
    logic resume_cfga;
    logic timer_init;
    logic off_go;
    logic fifo_clr;
    logic pwu_wakeup;
    logic run_mode;
    logic pwu_active;
  } rmsq_ctl_t;
endpackage

// file: core/rmsq_timer.sv
// Loadable down counter for one timeout timer
`timescale 1ns/100ps
module rmsq_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic run,
  input wire logic [rmsq_pkg::TMR_W-1:0] reload,
  output logic expire,
  output logic [rmsq_pkg::TMR_W-1:0] count
);
  typedef struct packed {
    logic [rmsq_pkg::TMR_W-1:0] cnt;
    logic exp;
  } rmsq_tmr_st_t;

  rmsq_tmr_st_t q;
  rmsq_tmr_st_t d;

  always_comb begin
    d = q;
    d.exp = 1'b0;
    if (load) begin
      d.cnt = reload;
    end else if (run && q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
      // Zero reload never expires
      d.exp = (q.cnt == {{(rmsq_pkg::TMR_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.exp;
  assign count = q.cnt;
endmodule

// file: core/rmsq_cmd_decode.sv
// Turns command register writes into single-cycle pulses
`timescale 1ns/100ps
module rmsq_cmd_decode (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr,
  input wire logic [1:0] wdat,
  input wire logic [1:0] ext_sel,
  output logic ext_to,
  output logic ext_eom
);
  typedef struct packed {
    logic to;
    logic end_of_message;
  } rmsq_cmd_st_t;

  rmsq_cmd_st_t q;
  rmsq_cmd_st_t d;
  logic ok;

  always_comb begin
    // Dropped silently while internal blocks still own the stream
    ok = wr && (ext_sel != rmsq_pkg::EXT_OFF);
    d.to = ok && wdat[rmsq_pkg::CMD_EXT_TO];
    d.end_of_message = ok && wdat[rmsq_pkg::CMD_EXT_EOM];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ext_to = q.to;
  assign ext_eom = q.end_of_message;
endmodule

// file: tb/rmsq_props.sv
// Concurrent checks on the ports of the run mode sequencer
`timescale 1ns/100ps
module rmsq_props (
  input wire logic clk,
  input wire logic srst,
  input wire rmsq_pkg::rmsq_wb_req_t wb_req,
  input wire rmsq_pkg::rmsq_wb_rsp_t wb_rsp,
  input wire rmsq_pkg::rmsq_rx_ev_t rx_ev,
  input wire rmsq_pkg::rmsq_ctl_t ctl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  ack_answer_a: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  resume_leaves_a: assert property (ctl.resume_next || ctl.resume_cfga || ctl.off_go |-> !ctl.run_mode)
    else $error("resume while still in run mode");
  wake_enter_a: assert property (!ctl.run_mode && rx_ev.wakeup |=> ctl.run_mode)
    else $error("wake-up did not enter run mode");
  cfga_init_a: assert property (ctl.resume_cfga |-> ctl.timer_init)
    else $error("config A restart without timer init");
  init_cause_a: assert property (ctl.timer_init |-> ctl.resume_cfga || ctl.resume_next || ctl.off_go)
    else $error("timer init without restart");
  off_last_a: assert property (ctl.off_go |-> !ctl.resume_next && $past(rx_ev.last_cfg))
    else $error("off period without last config");
  pwu_run_a: assert property (ctl.pwu_active |-> ctl.run_mode)
    else $error("parallel search outside run mode");
  pwu_loss_a: assert property (ctl.pwu_active && !rx_ev.sym_sync |-> ##[1:2] !ctl.pwu_active)
    else $error("parallel search kept after sync loss");
  pwu_found_a: assert property (ctl.pwu_wakeup |-> $past(ctl.pwu_active))
    else $error("parallel wake-up while search idle");
  cover property (ctl.resume_cfga && ctl.timer_init);
  cover property (ctl.off_go);
  cover property (ctl.pwu_wakeup);
endmodule

// file: tb/rmsq_front_model.sv
// Receive front end model feeding events to the sequencer
`timescale 1ns/100ps
module rmsq_front_model (
  input wire logic clk,
  input wire logic srst,
  input wire rmsq_pkg::rmsq_rx_ev_t stim,
  output rmsq_pkg::rmsq_rx_ev_t rx_ev
);
  // Registered so events change just after an edge
  always_ff @(posedge clk) begin
    rx_ev <= srst ? '0 : stim;
  end
endmodule

// file: tb/rmsq_sequencer_tb.sv
// Self-checking bench of the run mode sequencer
`timescale 1ns/100ps
module rmsq_sequencer_tb;
  localparam logic [7:0] ADRS [6] = '{rmsq_pkg::ADR_CTRL, rmsq_pkg::ADR_SYNC_TO, rmsq_pkg::ADR_FID_TO,
    rmsq_pkg::ADR_EOM_TO, rmsq_pkg::ADR_CMD, 8'h1c};
  localparam logic [31:0] EXPS [6] = '{32'h0, 32'h400, 32'h1000, 32'h4000, 32'h0, 32'h0};
  logic clk;
  logic srst;
  rmsq_pkg::rmsq_wb_req_t req;
  rmsq_pkg::rmsq_wb_rsp_t rsp;
  rmsq_pkg::rmsq_rx_ev_t ev;
  rmsq_pkg::rmsq_rx_ev_t rx;
  rmsq_pkg::rmsq_ctl_t ctl;
  rmsq_pkg::rmsq_ctl_t seen;
  logic [31:0] x;
  logic [31:0] q;
  logic [31:0] r;
  logic [7:0] c;
  logic [7:0] ch;
  int bad_count;
  int tests_run;
  rmsq_sequencer i_rmsq_sequencer (.clk(clk), .srst(srst), .wb_req(req), .wb_rsp(rsp), .rx_ev(rx), .ctl(ctl));
  rmsq_front_model i_rmsq_front_model (.clk(clk), .srst(srst), .stim(ev), .rx_ev(rx));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task results();
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do begin
      @(posedge clk);
      i++;
    end while (rsp.ack !== 1'b1 && i < 20);
    q = rsp.dat;
    req <= '0;
    if (rsp.ack !== 1'b1) begin
      chk("ack", 32'h0, 32'h1);
      results();
    end
  endtask
  task pulse(input int f);
    @(posedge clk);
    case (f)
      0: ev.wakeup <= 1'b1;
      1: ev.frame_start <= 1'b1;
      default: ev.msg_end <= 1'b1;
    endcase
    @(posedge clk);
    ev.wakeup <= 1'b0;
    ev.frame_start <= 1'b0;
    ev.msg_end <= 1'b0;
  endtask
  // Gathers every control pulse over a bounded window
  task watch(input int n, input logic stop);
    seen = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      seen = seen | ctl;
      if (stop && (seen.resume_next || seen.resume_cfga)) break;
    end
  endtask
  initial begin
    srst = 1'b1;
    req = '0;
    ev = '0;
    x = 32'd80527;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, ADRS[i], 32'h0);
      chk("reset value", q, EXPS[i]);
    end
    r = rnd();
    wb(1'b1, rmsq_pkg::ADR_CTRL, r);
    wb(1'b0, rmsq_pkg::ADR_CTRL, 32'h0);
    chk("ctrl", q, {24'h0, r[7:0]});
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? 8'h01 : (k == 1) ? 8'h00 : 8'h20;
      wb(1'b1, rmsq_pkg::ADR_CTRL, {24'h0, c});
      wb(1'b1, rmsq_pkg::ADR_SYNC_TO, 32'h5);
      pulse(0);
      watch(60, 1'b1);
      chk("to cfga", seen.resume_cfga, c[0]);
      chk("to next", seen.resume_next, !c[0]);
      chk("to init", seen.timer_init, c[0] | c[5]);
      chk("cycle clear", seen.fifo_clr, 1'b1);
    end
    wb(1'b1, rmsq_pkg::ADR_SYNC_TO, 32'h0);
    ev.last_cfg <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      c = k ? 8'h40 : 8'h00;
      wb(1'b1, rmsq_pkg::ADR_CTRL, {24'h0, c});
      pulse(0);
      wb(1'b1, rmsq_pkg::ADR_CMD, 32'h1);
      watch(20, 1'b0);
      chk("ext off", seen.off_go, c[6]);
      chk("ext next", seen.resume_next, 1'b0);
    end
    ev.last_cfg <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, rmsq_pkg::ADR_CTRL, 32'h8 | (k << 1));
      pulse(0);
      r = rnd();
      ch = r[7:0];
      ev.channel <= ch;
      ev.cfg_b <= ch[0];
      pulse(1);
      watch(2, 1'b0);
      chk("frame clear", seen.fifo_clr, 1'b1);
      pulse(2);
      watch(12, 1'b0);
      chk("eom next", seen.resume_next, k == 0);
      chk("eom cfga", seen.resume_cfga, k == 1);
      chk("eom stay", ctl.run_mode, k == 2);
      wb(1'b0, rmsq_pkg::ADR_CAPTURE, 32'h0);
      chk("capture", q, {22'h0, 1'b1, ch[0], ch});
    end
    wb(1'b1, rmsq_pkg::ADR_CTRL, 32'h14);
    for (int k = 0; k < 2; k++) begin
      pulse(1);
      pulse(2);
      ev.sym_sync <= 1'b1;
      watch(6, 1'b0);
      chk("pwu on", ctl.pwu_active, 1'b1);
      if (k) ev.sym_sync <= 1'b0;
      watch(6, 1'b0);
      pulse(0);
      watch(6, 1'b0);
      chk("pwu wake", seen.pwu_wakeup, !k);
    end
    wb(1'b1, rmsq_pkg::ADR_CTRL, 32'h54);
    ev.sym_sync <= 1'b1;
    wb(1'b1, rmsq_pkg::ADR_CMD, 32'h2);
    watch(6, 1'b0);
    chk("rearm clear", seen.fifo_clr, 1'b1);
    chk("pwu rearm", ctl.pwu_active, 1'b1);
    results();
  end
endmodule
bind rmsq_sequencer rmsq_props i_rmsq_props (.clk(clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .rx_ev(rx_ev), .ctl(ctl));
